// [verilog/cif_defs.vh]
/*
  cif_defs.vh: register indices, field positions and bus answer codes
  for the identifier tag and acceptance mask register set.
  Assumes: included by its bare name; byte address = 4 * index.
*/
`ifndef CIF_DEFS_VH
`define CIF_DEFS_VH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define CIF_PAGE_IDX 8'hb1
`define CIF_CTRL_IDX 8'hb3
`define CIF_HIT_IDX 8'hb4
`define CIF_TAG1_IDX 8'hbc
`define CIF_TAG2_IDX 8'hbd
`define CIF_TAG3_IDX 8'hbe
`define CIF_TAG4_IDX 8'hbf
`define CIF_MSK1_IDX 8'hc4
`define CIF_MSK2_IDX 8'hc5
`define CIF_MSK3_IDX 8'hc6
`define CIF_MSK4_IDX 8'hc7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CIF_PAGE_LSB 4
`define CIF_CTRL_EXT_BIT 4
`define CIF_CTRL_RXEN_BIT 7
`define CIF_RTR_BIT 2
`define CIF_RB1_BIT 1
`define CIF_RB0_BIT 0
`define CIF_IDE_BIT 0

// ----------------------------------------------------------------
// reset values and answer codes
// ----------------------------------------------------------------
`define CIF_PAGE_RST 4'h0
`define CIF_RESP_OKAY 2'h0
`define CIF_RESP_SLVERR 2'h2

`endif

// [verilog/cif_obj_match.v]
/*
  cif_obj_match.v: acceptance compare of one message object against a
  received identifier, remote request and extension bit.
  Assumes: tag and mask words hold the four bytes, byte 1 in bits 31:24.
*/
`timescale 1ns/1ps
`include "cif_defs.vh"

module cif_obj_match (
  input wire [31:0] tag,
  input wire [31:0] mask,
  input wire ext,
  input wire [28:0] rx_id,
  input wire rx_rtr,
  input wire rx_ide,
  output wire hit
);

  wire id_miss_ext;
  wire id_miss_std;
  wire rtr_miss;
  wire ide_miss;

  // extended view: tag bits 31:3 are identifier 28:0
  assign id_miss_ext = |((rx_id ^ tag[31:3]) & mask[31:3]);
  // standard view: tag bits 31:21 are identifier 10:0
  assign id_miss_std = |((rx_id[10:0] ^ tag[31:21]) & mask[31:21]);
  assign rtr_miss = (rx_rtr ^ tag[`CIF_RTR_BIT]) & mask[`CIF_RTR_BIT];
  assign ide_miss = (rx_ide ^ ext) & mask[`CIF_IDE_BIT];
  assign hit = ~((ext ? id_miss_ext : id_miss_std) | rtr_miss | ide_miss);

endmodule // cif_obj_match

// [verilog/cif_filter.v]
/*
  cif_filter.v: per-object identifier tag and acceptance mask registers
  over AXI4-Lite, the per-object receive filter and the transmit tag read-out.
  Assumes: one clock CLK, RESETN asynchronous active low, frame inputs
  synchronous to CLK, software programs tag and mask before enabling.
*/
//
// Contract
// - mask 0 forces match, 1 compares
// - mask used on receive only
// - extended tag bytes carry identifier 28:0
// - extended byte four: rtr, rb1, rb0
// - standard byte three reserved; rtr, rb0
// - standard mask bits 10:0 layout
// - extended mask bits 28:0 layout
// - mask byte four: rtr, ide compare
// - reserved bits read undefined, never set
// - tag and mask undefined after reset
// - extension bit selects standard/extended view
// - access goes to selected object 0-14
`timescale 1ns/1ps
`include "cif_defs.vh"

module cif_filter #(
  parameter NUM_OBJ = 15,
  parameter ADDR_W = 12
) (
  input wire CLK,
  input wire RESETN,
  input wire [ADDR_W-1:0] AWADDR,
  input wire AWVALID,
  output wire AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output wire WREADY,
  output wire [1:0] BRESP,
  output wire BVALID,
  input wire BREADY,
  input wire [ADDR_W-1:0] ARADDR,
  input wire ARVALID,
  output wire ARREADY,
  output wire [31:0] RDATA,
  output wire [1:0] RRESP,
  output wire RVALID,
  input wire RREADY,
  input wire RX_VALID,
  input wire [28:0] RX_ID,
  input wire RX_RTR,
  input wire RX_IDE,
  output wire RX_DONE,
  output wire [NUM_OBJ-1:0] RX_HIT,
  input wire TX_REQ,
  input wire [3:0] TX_OBJ,
  output wire TX_VALID,
  output wire [28:0] TX_ID,
  output wire TX_IDE,
  output wire TX_RTR,
  output wire TX_RB1,
  output wire TX_RB0
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg [31:0] tag_mem [0:NUM_OBJ-1];
  reg [31:0] mask_mem [0:NUM_OBJ-1];
  reg [NUM_OBJ-1:0] ext_q;
  reg [NUM_OBJ-1:0] rxen_q;
  reg [3:0] page_q;
  reg [NUM_OBJ-1:0] last_hit_q;

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  reg awready_q;
  reg wready_q;
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] waddr_q;
  reg [7:0] wbyte_q;
  reg wstrb0_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  reg rx_done_q;
  reg [NUM_OBJ-1:0] rx_hit_q;
  reg tx_valid_q;
  reg [28:0] tx_id_q;
  reg tx_ide_q;
  reg tx_rtr_q;
  reg tx_rb1_q;
  reg tx_rb0_q;

  wire page_ok;
  wire [7:0] ridx;
  wire [NUM_OBJ-1:0] cmp_hit;
  wire do_write;
  reg [31:0] rd_word;
  reg rd_ok;
  reg wr_ok;
  reg [31:0] sel_tag;
  reg [31:0] sel_mask;
  reg sel_ext;
  reg sel_rxen;

  assign page_ok = (page_q < NUM_OBJ);
  assign ridx = ARADDR[9:2];
  assign do_write = aw_have_q && w_have_q && !bvalid_q;

  // ----------------------------------------------------------------
  // selected object view
  // ----------------------------------------------------------------
  always @* begin
    sel_tag = 32'h0;
    sel_mask = 32'h0;
    sel_ext = 1'b0;
    sel_rxen = 1'b0;
    if (page_ok) begin
      sel_tag = tag_mem[page_q];
      sel_mask = mask_mem[page_q];
      sel_ext = ext_q[page_q];
      sel_rxen = rxen_q[page_q];
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always @* begin
    rd_word = 32'h0;
    rd_ok = 1'b1;
    case (ridx)
      `CIF_PAGE_IDX: rd_word = {24'h0, page_q, 4'h0};
      `CIF_CTRL_IDX: rd_word = {24'h0, sel_rxen, 2'h0, sel_ext, 4'h0};
      `CIF_HIT_IDX: rd_word = {{(32-NUM_OBJ){1'b0}}, last_hit_q};
      // reserved positions return whatever is stored
      `CIF_TAG1_IDX: rd_word = {24'h0, sel_tag[31:24]};
      `CIF_TAG2_IDX: rd_word = {24'h0, sel_tag[23:16]};
      `CIF_TAG3_IDX: rd_word = {24'h0, sel_tag[15:8]};
      `CIF_TAG4_IDX: rd_word = {24'h0, sel_tag[7:0]};
      `CIF_MSK1_IDX: rd_word = {24'h0, sel_mask[31:24]};
      `CIF_MSK2_IDX: rd_word = {24'h0, sel_mask[23:16]};
      `CIF_MSK3_IDX: rd_word = {24'h0, sel_mask[15:8]};
      `CIF_MSK4_IDX: rd_word = {24'h0, sel_mask[7:0]};
      default: rd_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  always @* begin
    case (waddr_q)
      `CIF_PAGE_IDX, `CIF_CTRL_IDX, `CIF_HIT_IDX: wr_ok = 1'b1;
      `CIF_TAG1_IDX, `CIF_TAG2_IDX, `CIF_TAG3_IDX, `CIF_TAG4_IDX: wr_ok = 1'b1;
      `CIF_MSK1_IDX, `CIF_MSK2_IDX, `CIF_MSK3_IDX, `CIF_MSK4_IDX: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= 8'h0;
      wbyte_q <= 8'h0;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `CIF_RESP_OKAY;
    end else begin
      if (!aw_have_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (!w_have_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (AWVALID && awready_q) begin
        awready_q <= 1'b0;
        aw_have_q <= 1'b1;
        waddr_q <= AWADDR[9:2];
      end
      if (WVALID && wready_q) begin
        wready_q <= 1'b0;
        w_have_q <= 1'b1;
        wbyte_q <= WDATA[7:0];
        wstrb0_q <= WSTRB[0];
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `CIF_RESP_OKAY : `CIF_RESP_SLVERR;
      end
      if (bvalid_q && BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      page_q <= `CIF_PAGE_RST;
      ext_q <= {NUM_OBJ{1'b0}};
      rxen_q <= {NUM_OBJ{1'b0}};
    end else if (do_write && wstrb0_q) begin
      if (waddr_q == `CIF_PAGE_IDX) begin
        page_q <= wbyte_q[`CIF_PAGE_LSB+3:`CIF_PAGE_LSB];
      end
      if (waddr_q == `CIF_CTRL_IDX && page_ok) begin
        ext_q[page_q] <= wbyte_q[`CIF_CTRL_EXT_BIT];
        rxen_q[page_q] <= wbyte_q[`CIF_CTRL_RXEN_BIT];
      end
    end
  end

  // tag and mask carry no reset: undefined until software programs them
  always @(posedge CLK) begin
    if (do_write && wstrb0_q && page_ok) begin
      case (waddr_q)
        `CIF_TAG1_IDX: tag_mem[page_q][31:24] <= wbyte_q;
        `CIF_TAG2_IDX: tag_mem[page_q][23:16] <= wbyte_q;
        `CIF_TAG3_IDX: tag_mem[page_q][15:8] <= wbyte_q;
        `CIF_TAG4_IDX: tag_mem[page_q][7:0] <= wbyte_q;
        `CIF_MSK1_IDX: mask_mem[page_q][31:24] <= wbyte_q;
        `CIF_MSK2_IDX: mask_mem[page_q][23:16] <= wbyte_q;
        `CIF_MSK3_IDX: mask_mem[page_q][15:8] <= wbyte_q;
        `CIF_MSK4_IDX: mask_mem[page_q][7:0] <= wbyte_q;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `CIF_RESP_OKAY;
    end else begin
      if (!rvalid_q && !(ARVALID && arready_q)) begin
        arready_q <= 1'b1;
      end
      if (ARVALID && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_ok ? `CIF_RESP_OKAY : `CIF_RESP_SLVERR;
      end
      if (rvalid_q && RREADY) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive filter
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OBJ; gi = gi + 1) begin : g_obj
      cif_obj_match u_match (
        .tag(tag_mem[gi]),
        .mask(mask_mem[gi]),
        .ext(ext_q[gi]),
        .rx_id(RX_ID),
        .rx_rtr(RX_RTR),
        .rx_ide(RX_IDE),
        .hit(cmp_hit[gi])
      );
    end
  endgenerate

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_done_q <= 1'b0;
      rx_hit_q <= {NUM_OBJ{1'b0}};
      last_hit_q <= {NUM_OBJ{1'b0}};
    end else begin
      rx_done_q <= RX_VALID;
      if (RX_VALID) begin
        rx_hit_q <= cmp_hit & rxen_q;
        last_hit_q <= cmp_hit & rxen_q;
      end else begin
        rx_hit_q <= {NUM_OBJ{1'b0}};
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit tag read-out, mask not involved
  // ----------------------------------------------------------------
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_valid_q <= 1'b0;
      tx_id_q <= 29'h0;
      tx_ide_q <= 1'b0;
      tx_rtr_q <= 1'b0;
      tx_rb1_q <= 1'b0;
      tx_rb0_q <= 1'b0;
    end else begin
      tx_valid_q <= TX_REQ && (TX_OBJ < NUM_OBJ);
      if (TX_REQ && (TX_OBJ < NUM_OBJ)) begin
        tx_ide_q <= ext_q[TX_OBJ];
        tx_id_q <= ext_q[TX_OBJ] ? tag_mem[TX_OBJ][31:3] : {18'h0, tag_mem[TX_OBJ][31:21]};
        tx_rtr_q <= tag_mem[TX_OBJ][`CIF_RTR_BIT];
        tx_rb1_q <= ext_q[TX_OBJ] & tag_mem[TX_OBJ][`CIF_RB1_BIT];
        tx_rb0_q <= tag_mem[TX_OBJ][`CIF_RB0_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign AWREADY = awready_q;
  assign WREADY = wready_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
  assign RX_DONE = rx_done_q;
  assign RX_HIT = rx_hit_q;
  assign TX_VALID = tx_valid_q;
  assign TX_ID = tx_id_q;
  assign TX_IDE = tx_ide_q;
  assign TX_RTR = tx_rtr_q;
  assign TX_RB1 = tx_rb1_q;
  assign TX_RB0 = tx_rb0_q;

endmodule // cif_filter

// [verilog/cif_none_placeholder_unused.v]
/*
  cif_none_placeholder_unused.v: holds no logic.
  Assumes: nothing refers to it; the filter lives in cif_filter.v and cif_obj_match.v.
*/

// [sim/cif_filter_asserts.sv]
/*
  cif_filter_asserts.sv: port checker for the tag and mask filter.
  Assumes: bound to cif_filter, one clock CLK, RESETN active low.
*/
`timescale 1ns/1ps
module cif_filter_asserts #(
  parameter NUM_OBJ = 15
) (
  input wire CLK,
  input wire RESETN,
  input wire [1:0] BRESP,
  input wire BVALID,
  input wire BREADY,
  input wire [31:0] RDATA,
  input wire RVALID,
  input wire RREADY,
  input wire RX_VALID,
  input wire RX_DONE,
  input wire [NUM_OBJ-1:0] RX_HIT,
  input wire TX_REQ,
  input wire [3:0] TX_OBJ,
  input wire TX_VALID,
  input wire [28:0] TX_ID,
  input wire TX_IDE,
  input wire TX_RTR,
  input wire TX_RB1
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  // ----------------------------------------------------------------
  // frame paths
  // ----------------------------------------------------------------
  a_rx_done_next: assert property (RX_VALID |=> RX_DONE) else $error("rx done missing");
  a_rx_done_only: assert property (!RX_VALID |=> !RX_DONE) else $error("rx done unasked");
  a_hit_idle_zero: assert property (!RX_DONE |-> RX_HIT == '0) else $error("hit outside done");
  a_tx_valid_next: assert property (TX_REQ && TX_OBJ < 4'hf |=> TX_VALID) else $error("tx valid missing");
  a_tx_fields_hold: assert property (!TX_REQ |=> !TX_VALID && $stable(TX_ID) && $stable(TX_RTR))
    else $error("tx fields moved");
  a_std_tx_form: assert property (TX_VALID && !TX_IDE |-> TX_ID[28:11] == 18'h0 && !TX_RB1)
    else $error("standard tx form");
  // ----------------------------------------------------------------
  // register bus, and covers for receive hit, extended transmit and slave error
  // ----------------------------------------------------------------
  a_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("bresp dropped");
  a_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("rdata dropped");
  a_rdata_byte: assert property (RVALID |-> RDATA[31:8] == 24'h0) else $error("rdata upper bits");
  c_rx_hit: cover property (RX_DONE && RX_HIT != '0);
  c_tx_ext: cover property (TX_VALID && TX_IDE);
  c_slverr: cover property (BVALID && BRESP == 2'h2);
endmodule // cif_filter_asserts

bind cif_filter cif_filter_asserts #(.NUM_OBJ(NUM_OBJ)) cif_filter_asserts_i (.CLK(CLK), .RESETN(RESETN),
  .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
  .RX_VALID(RX_VALID), .RX_DONE(RX_DONE), .RX_HIT(RX_HIT), .TX_REQ(TX_REQ), .TX_OBJ(TX_OBJ),
  .TX_VALID(TX_VALID), .TX_ID(TX_ID), .TX_IDE(TX_IDE), .TX_RTR(TX_RTR), .TX_RB1(TX_RB1));

// [sim/cif_filter_tb_top.sv]
/*
  cif_filter_tb_top.sv: self-checking bench for the tag and mask filter.
  Assumes: cif_filter with default parameters, byte address = 4 * index.
*/
`timescale 1ns/1ps
`include "cif_defs.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; $display("BAD %0t got %h want %h", $time, a, b); end end
module cif_filter_tb_top;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [11:0] AWADDR = '0;
  logic [11:0] ARADDR = '0;
  logic [31:0] WDATA = '0;
  logic [3:0] WSTRB = 4'h1;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic RX_VALID = 1'b0, RX_RTR = 1'b0, RX_IDE = 1'b0, TX_REQ = 1'b0;
  logic [28:0] RX_ID = '0;
  logic [3:0] TX_OBJ = '0;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, RX_DONE, TX_VALID, TX_IDE, TX_RTR, TX_RB1, TX_RB0;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA;
  wire [14:0] RX_HIT;
  wire [28:0] TX_ID;
  int bad_count = 0;
  int n_compared = 0;
  localparam logic [28:0] EID = 29'h12345678;
  localparam logic [10:0] SID = 11'h5a3;

  always #20 CLK = ~CLK;

  cif_filter cif_filter_i (.CLK(CLK), .RESETN(RESETN), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .RX_VALID(RX_VALID), .RX_ID(RX_ID), .RX_RTR(RX_RTR), .RX_IDE(RX_IDE),
    .RX_DONE(RX_DONE), .RX_HIT(RX_HIT), .TX_REQ(TX_REQ), .TX_OBJ(TX_OBJ), .TX_VALID(TX_VALID), .TX_ID(TX_ID),
    .TX_IDE(TX_IDE), .TX_RTR(TX_RTR), .TX_RB1(TX_RB1), .TX_RB0(TX_RB0));

  // ----------------------------------------------------------------
  // bus and frame tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic guard(inout int n);
    n++;
    if (n > 100) begin
      bad_count++;
      results();
    end
  endtask

  // ready and valid sampled at the falling edge hold through the next rising edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a, w, b;
    int n;
    n = 0;
    b = 1'b0;
    @(posedge CLK);
    AWADDR <= {2'h0, idx, 2'h0};
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!b) begin
      @(negedge CLK);
      guard(n);
      a = AWVALID && AWREADY === 1'b1;
      w = WVALID && WREADY === 1'b1;
      b = BVALID === 1'b1;
      if (b) `CHK(BRESP, er)
      @(posedge CLK);
      if (a) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
    end
    BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a, r;
    int n;
    n = 0;
    r = 1'b0;
    @(posedge CLK);
    ARADDR <= {2'h0, idx, 2'h0};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!r) begin
      @(negedge CLK);
      guard(n);
      a = ARVALID && ARREADY === 1'b1;
      r = RVALID === 1'b1;
      if (r) `CHK({RRESP, RDATA}, {er, 24'h0, d})
      @(posedge CLK);
      if (a) ARVALID <= 1'b0;
    end
    RREADY <= 1'b0;
  endtask

  task automatic wrd(input logic [7:0] idx, input logic [7:0] d);
    wr(idx, d, `CIF_RESP_OKAY);
    rd(idx, d, `CIF_RESP_OKAY);
  endtask

  task automatic prog(input logic [31:0] t, input logic [31:0] m);
    for (int i = 0; i < 4; i++) begin
      wrd(8'(`CIF_TAG1_IDX + i), t[31 - 8 * i -: 8]);
      wrd(8'(`CIF_MSK1_IDX + i), m[31 - 8 * i -: 8]);
    end
  endtask

  task automatic rx(input logic [28:0] id, input logic rtr, input logic extended_format_select, input logic [14:0] h);
    @(posedge CLK);
    RX_ID <= id;
    RX_RTR <= rtr;
    RX_IDE <= extended_format_select;
    RX_VALID <= 1'b1;
    @(posedge CLK);
    RX_VALID <= 1'b0;
    @(negedge CLK);
    `CHK({RX_DONE, RX_HIT}, {1'b1, h})
  endtask

  // f holds ide, rtr, rb1, rb0, id
  task automatic tx(input logic [3:0] obj, input logic [32:0] f);
    @(posedge CLK);
    TX_OBJ <= obj;
    TX_REQ <= 1'b1;
    @(posedge CLK);
    TX_REQ <= 1'b0;
    @(negedge CLK);
    `CHK({TX_VALID, TX_IDE, TX_RTR, TX_RB1, TX_RB0, TX_ID}, {1'b1, f})
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge CLK);
    RESETN <= 1'b1;
    wrd(`CIF_PAGE_IDX, 8'h30);
    prog({EID, 3'h6}, 32'hfffffffd);
    wrd(`CIF_CTRL_IDX, 8'h90);
    tx(4'h3, {4'he, EID});
    rx(EID, 1'b1, 1'b1, 15'h0008);
    rx(EID ^ 29'h20, 1'b1, 1'b1, 15'h0);
    rx(EID, 1'b0, 1'b1, 15'h0);
    rx(EID, 1'b1, 1'b0, 15'h0);
    wrd(`CIF_MSK3_IDX, 8'hfe);
    wrd(`CIF_MSK4_IDX, 8'hf8);
    rx(EID ^ 29'h20, 1'b0, 1'b0, 15'h0008);
    rx(EID ^ 29'h8, 1'b1, 1'b1, 15'h0);
    wrd(`CIF_MSK1_IDX, 8'h7f);
    rx(EID ^ 29'h10000000, 1'b1, 1'b1, 15'h0008);
    tx(4'h3, {4'he, EID});
    wrd(`CIF_PAGE_IDX, 8'h50);
    prog({SID, 21'h5}, {11'h7ff, 21'h5});
    wrd(`CIF_CTRL_IDX, 8'h80);
    tx(4'h5, {4'h5, 18'h0, SID});
    rx({18'h0, SID}, 1'b1, 1'b0, 15'h0020);
    rd(`CIF_HIT_IDX, 8'h20, `CIF_RESP_OKAY);
    rx({18'h0, SID ^ 11'h1}, 1'b1, 1'b0, 15'h0);
    rx({18'h0, SID}, 1'b1, 1'b1, 15'h0);
    wr(`CIF_PAGE_IDX, 8'hf0, `CIF_RESP_OKAY);
    wr(`CIF_TAG1_IDX, 8'h11, `CIF_RESP_OKAY);
    rd(`CIF_TAG1_IDX, 8'h00, `CIF_RESP_OKAY);
    wrd(`CIF_PAGE_IDX, 8'h30);
    // byte lane 0 off: the write is answered but stores nothing
    WSTRB <= 4'h0;
    wr(`CIF_TAG1_IDX, 8'h22, `CIF_RESP_OKAY);
    WSTRB <= 4'h1;
    rd(`CIF_TAG1_IDX, EID[28:21], `CIF_RESP_OKAY);
    rd(8'hb0, 8'h00, `CIF_RESP_SLVERR);
    wr(8'hc8, 8'h5a, `CIF_RESP_SLVERR);
    results();
  end
endmodule // cif_filter_tb_top
